// ===== logic/amp_reset_power_pkg.sv
// constants and types for the amplifier reset and power control block
package amp_reset_power_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] MODULE_RESET_CONTROL_IDX  = 8'h01;
    localparam logic [7:0] POWER_REQUEST_CONTROL_IDX = 8'h02;
    localparam logic [7:0] CHANNEL_MUTE_CONTROL_IDX  = 8'h03;
    localparam logic [7:0] STATUS_IDX                = 8'h04;
    localparam int         ADDR_W                    = 12;
    // field positions
    localparam int MODULE_RESET_POS     = 4;
    localparam int REGISTER_RESET_POS   = 0;
    localparam int PROCESSOR_RESET_POS  = 7;
    localparam int STANDBY_REQUEST_POS  = 4;
    localparam int POWERDOWN_REQUEST_POS = 0;
    localparam int LEFT_MUTE_POS        = 4;
    localparam int RIGHT_MUTE_POS       = 0;
    // reset values and write masks
    localparam logic [7:0] MODULE_RESET_RESET  = 8'h00;
    localparam logic [7:0] POWER_REQUEST_RESET = 8'h80;
    localparam logic [7:0] MUTE_RESET          = 8'h00;
    localparam logic [7:0] POWER_WRITE_MASK    = 8'h91;
    localparam logic [7:0] MUTE_WRITE_MASK     = 8'h1f;
    // reset pulse lengths
    localparam int         MODULE_RESET_NS = 40;
    localparam int         CLOCK_PERIOD_NS = 4;
    localparam logic [3:0] MODULE_RESET_CYCLES =
        4'((MODULE_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [3:0] REGISTER_RESET_CYCLES = 4'h2;
    localparam logic [3:0] COUNT_ZERO            = 4'h0;
    localparam logic [3:0] COUNT_ONE             = 4'h1;

    typedef enum logic [1:0]
    {
        PWR_ACTIVE    = 2'b00,
        PWR_STANDBY   = 2'b01,
        PWR_POWERDOWN = 2'b10
    } power_state_type;

    typedef enum logic [1:0]
    {
        RST_IDLE     = 2'b00,
        RST_MODULE   = 2'b01,
        RST_REGISTER = 2'b10
    } reset_state_type;

    typedef struct packed
    {
        logic modulesInReset;
        logic processorInReset;
        logic ramClear;
        logic executeFromRom;
    } reset_out_type;

    typedef struct packed
    {
        logic standbyPower;
        logic chargePumpOff;
        logic leftMute;
        logic rightMute;
    } power_out_type;
endpackage

// ===== logic/amp_reset_power_control.sv
// reset, standby and powerdown control with an APB register slave
`timescale 1ns/1ps
`default_nettype none
module amp_reset_power_control
    import amp_reset_power_pkg::*;
(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // clock error from the detector, asynchronous
    input  wire logic                clockError,
    // controls to the datapath
    output var  reset_out_type       resetOut,
    output var  power_out_type       powerOut
);
    function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hitReg = (a == ADDR_W'({idx, 2'b00}));
    endfunction

    logic [7:0]      moduleResetReg;
    logic [7:0]      powerReg;
    logic [7:0]      muteReg;
    reset_state_type resetStateReg;
    logic [3:0]      resetCountReg;
    power_state_type powerStateReg;
    power_state_type powerStateNext;
    logic            clockErrorMetaReg;
    logic            clockErrorSyncReg;
    logic            ramSourceRomReg;

    wire logic accessPhase = psel && penable;
    wire logic writeHit    = accessPhase && pwrite;
    wire logic inStandby   = (powerStateReg != PWR_ACTIVE);
    wire logic modWrite    = writeHit && hitReg(paddr, MODULE_RESET_CONTROL_IDX);
    // module reset refused outside standby
    wire logic startModule = modWrite && pwdata[MODULE_RESET_POS] && inStandby
                             && (resetStateReg == RST_IDLE);
    // register reset relies on software keeping to standby
    wire logic startRegReset = modWrite && pwdata[REGISTER_RESET_POS] && !startModule
                               && (resetStateReg == RST_IDLE);
    wire logic regResetDone  = (resetStateReg == RST_REGISTER) && (resetCountReg == COUNT_ONE);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clockErrorMetaReg <= 1'b0;
            clockErrorSyncReg <= 1'b0;
        end
        else
        begin
            clockErrorMetaReg <= clockError;
            clockErrorSyncReg <= clockErrorMetaReg;
        end
    end

    // reset sequencer
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            resetStateReg  <= RST_IDLE;
            resetCountReg  <= COUNT_ZERO;
            moduleResetReg <= MODULE_RESET_RESET;
        end
        else
        begin
            case (resetStateReg)
                RST_IDLE:
                begin
                    if (startModule)
                    begin
                        resetStateReg  <= RST_MODULE;
                        resetCountReg  <= MODULE_RESET_CYCLES;
                        moduleResetReg[MODULE_RESET_POS] <= 1'b1;
                    end
                    else if (startRegReset)
                    begin
                        resetStateReg  <= RST_REGISTER;
                        resetCountReg  <= REGISTER_RESET_CYCLES;
                        moduleResetReg[REGISTER_RESET_POS] <= 1'b1;
                    end
                end
                default:
                begin
                    if (resetCountReg == COUNT_ONE)
                    begin
                        resetStateReg  <= RST_IDLE;
                        resetCountReg  <= COUNT_ZERO;
                        moduleResetReg <= MODULE_RESET_RESET;
                    end
                    else
                    begin
                        resetCountReg <= resetCountReg - COUNT_ONE;
                    end
                end
            endcase
        end
    end

    // mode registers; a register reset restores them
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerReg <= POWER_REQUEST_RESET;
            muteReg  <= MUTE_RESET;
        end
        else if (regResetDone)
        begin
            powerReg <= POWER_REQUEST_RESET;
            muteReg  <= MUTE_RESET;
        end
        else if (writeHit && hitReg(paddr, POWER_REQUEST_CONTROL_IDX))
        begin
            powerReg <= pwdata[7:0] & POWER_WRITE_MASK;
        end
        else if (writeHit && hitReg(paddr, CHANNEL_MUTE_CONTROL_IDX))
        begin
            muteReg <= pwdata[7:0] & MUTE_WRITE_MASK;
        end
    end

    // execution source; RAM content untouched by register reset
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ramSourceRomReg <= 1'b1;
        end
        else if (regResetDone || resetStateReg == RST_MODULE)
        begin
            ramSourceRomReg <= 1'b1;
        end
        else if (!powerReg[PROCESSOR_RESET_POS])
        begin
            ramSourceRomReg <= 1'b0;
        end
    end

    always_comb
    begin
        if (powerReg[POWERDOWN_REQUEST_POS])
        begin
            powerStateNext = PWR_POWERDOWN;
        end
        else if (powerReg[STANDBY_REQUEST_POS] || clockErrorSyncReg)
        begin
            powerStateNext = PWR_STANDBY;
        end
        else
        begin
            powerStateNext = PWR_ACTIVE;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerStateReg <= PWR_ACTIVE;
        end
        else
        begin
            powerStateReg <= powerStateNext;
        end
    end

    // datapath controls, all registered
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            resetOut <= '{modulesInReset: 1'b0, processorInReset: 1'b1, ramClear: 1'b0, executeFromRom: 1'b1};
            powerOut <= '0;
        end
        else
        begin
            resetOut.modulesInReset   <= (resetStateReg == RST_MODULE);
            // processor released only when software clears the bit
            resetOut.processorInReset <= powerReg[PROCESSOR_RESET_POS] || (resetStateReg == RST_MODULE);
            resetOut.ramClear         <= (resetStateReg == RST_MODULE);
            resetOut.executeFromRom   <= ramSourceRomReg;
            powerOut.standbyPower     <= (powerStateNext != PWR_ACTIVE);
            powerOut.chargePumpOff    <= (powerStateNext == PWR_POWERDOWN);
            // the ramp itself lives in the volume block; this is its target
            powerOut.leftMute         <= muteReg[LEFT_MUTE_POS];
            powerOut.rightMute        <= muteReg[RIGHT_MUTE_POS];
        end
    end

    // apb: zero-wait answer, unmapped reads zero with error
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable)
            begin
                if (hitReg(paddr, MODULE_RESET_CONTROL_IDX))
                begin
                    prdata <= {24'h00_0000, moduleResetReg};
                end
                else if (hitReg(paddr, POWER_REQUEST_CONTROL_IDX))
                begin
                    prdata <= {24'h00_0000, powerReg};
                end
                else if (hitReg(paddr, CHANNEL_MUTE_CONTROL_IDX))
                begin
                    prdata <= {24'h00_0000, muteReg};
                end
                else if (hitReg(paddr, STATUS_IDX))
                begin
                    prdata <= {28'h000_0000, clockErrorSyncReg, ramSourceRomReg, powerStateReg};
                end
                else
                begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // checks
    AST_MODULE_REFUSED: assert property (@(posedge mclk) disable iff (!reset_n)
        (modWrite && pwdata[MODULE_RESET_POS] && !inStandby) |=> (resetStateReg != RST_MODULE))
        else $error("module reset accepted outside standby");
    sequence moduleStart;
        startModule;
    endsequence
    AST_MODULE_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
        moduleStart |=> ##1 resetOut.modulesInReset && resetOut.processorInReset)
        else $error("module reset did not reach modules and processor");
    AST_RAM_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
        moduleStart |=> ##1 resetOut.ramClear)
        else $error("ram clear missing on module reset");
    AST_SELF_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
        moduleStart |=> ##10 (moduleResetReg == MODULE_RESET_RESET))
        else $error("module reset bit did not clear");
    AST_REG_RESET: assert property (@(posedge mclk) disable iff (!reset_n)
        regResetDone |=> (powerReg == POWER_REQUEST_RESET) && (muteReg == MUTE_RESET))
        else $error("mode registers not restored");
    AST_ROM_SOURCE: assert property (@(posedge mclk) disable iff (!reset_n)
        regResetDone |=> ##1 resetOut.executeFromRom)
        else $error("execution source not rom after register reset");
    AST_PROC_HELD: assert property (@(posedge mclk) disable iff (!reset_n)
        powerReg[PROCESSOR_RESET_POS] |=> resetOut.processorInReset)
        else $error("processor released while reset bit set");
    AST_CLOCK_ERROR: assert property (@(posedge mclk) disable iff (!reset_n)
        clockErrorSyncReg |=> powerOut.standbyPower)
        else $error("clock error did not enter standby");
    AST_POWERDOWN_WINS: assert property (@(posedge mclk) disable iff (!reset_n)
        (powerReg[POWERDOWN_REQUEST_POS] && powerReg[STANDBY_REQUEST_POS]) |=>
        (powerStateReg == PWR_POWERDOWN) && powerOut.chargePumpOff)
        else $error("standby won over powerdown");
    AST_STANDBY_PUMP: assert property (@(posedge mclk) disable iff (!reset_n)
        (powerStateNext == PWR_STANDBY) |=> powerOut.standbyPower && !powerOut.chargePumpOff)
        else $error("standby turned charge pump off");
    sequence regStart;
        startRegReset;
    endsequence
    AST_REG_SELF_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
        regStart |=> ##2 (moduleResetReg == MODULE_RESET_RESET))
        else $error("register reset bit did not clear");
    AST_POWERDOWN_PUMP: assert property (@(posedge mclk) disable iff (!reset_n)
        powerReg[POWERDOWN_REQUEST_POS] |=> powerOut.chargePumpOff && powerOut.standbyPower)
        else $error("powerdown left charge pump on");
    // the volume ramp downstream relies on the target lagging the register by one edge
    AST_MUTE_TARGET: assert property (@(posedge mclk) disable iff (!reset_n)
        (powerOut.leftMute == $past(muteReg[LEFT_MUTE_POS]))
        && (powerOut.rightMute == $past(muteReg[RIGHT_MUTE_POS])))
        else $error("mute target does not follow mute register");
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the reset and power control block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import amp_reset_power_pkg::*;
;
    logic                mclk;
    logic                reset_n;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                clockError;
    reset_out_type       resetOut;
    power_out_type       powerOut;
    logic [33:0]         expQ[$];
    int                  n_fail;
    int                  checked;
    logic [31:0]         rnd;

    localparam logic [ADDR_W-1:0] A_RST = 12'h004;
    localparam logic [ADDR_W-1:0] A_PWR = 12'h008;
    localparam logic [ADDR_W-1:0] A_MUTE = 12'h00c;
    localparam logic [ADDR_W-1:0] A_NONE = 12'h020;
    localparam logic [ADDR_W-1:0] A_STAT = 12'h010;

    amp_reset_power_control i_dut
    (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .clockError (clockError),
        .resetOut   (resetOut),
        .powerOut   (powerOut)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // expectation noted before the transfer, judged by the monitor
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] exp);
        expQ.push_back({~wr, err, exp});
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no local limit: a slave that never answers is caught by the watchdog
        while (pready !== 1'b1)
        begin
            @(posedge mclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    always @(posedge mclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            if (expQ.size() == 0)
                check("unexpected transfer", 32'h0000_0001, 32'h0000_0000);
            else
            begin
                check("pslverr", {31'h0, pslverr}, {31'h0, expQ[0][32]});
                if (expQ[0][33] === 1'b1)
                    check("prdata", prdata, expQ[0][31:0]);
                void'(expQ.pop_front());
            end
        end
    end

    initial
    begin
        #(20000 * 4);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        clockError = 1'b0;
        rnd = $urandom(52);
        waitc(10);
        reset_n <= 1'b1;
        apb(1'b0, A_RST, '0, 1'b0, 32'h0000_0000);
        apb(1'b0, A_PWR, '0, 1'b0, 32'h0000_0080);
        apb(1'b0, A_MUTE, '0, 1'b0, 32'h0000_0000);
        check("procInReset", {31'h0, resetOut.processorInReset}, 32'h0000_0001);
        check("execRom", {31'h0, resetOut.executeFromRom}, 32'h0000_0001);
        apb(1'b0, A_NONE, '0, 1'b1, 32'h0000_0000);
        apb(1'b1, A_NONE, 32'h0000_00ff, 1'b1, 32'h0000_0000);
        $display("test reset_values done");
        // refused while active
        apb(1'b1, A_RST, 32'h0000_0010, 1'b0, 32'h0000_0000);
        apb(1'b0, A_RST, '0, 1'b0, 32'h0000_0000);
        check("modInReset", {31'h0, resetOut.modulesInReset}, 32'h0000_0000);
        $display("test refused_module_reset done");
        apb(1'b1, A_PWR, 32'h0000_0090, 1'b0, 32'h0000_0000);
        waitc(3);
        check("standby", {31'h0, powerOut.standbyPower}, 32'h0000_0001);
        check("pumpOff", {31'h0, powerOut.chargePumpOff}, 32'h0000_0000);
        apb(1'b1, A_RST, 32'h0000_0010, 1'b0, 32'h0000_0000);
        apb(1'b0, A_RST, '0, 1'b0, 32'h0000_0010);
        check("modInReset", {31'h0, resetOut.modulesInReset}, 32'h0000_0001);
        check("procInReset", {31'h0, resetOut.processorInReset}, 32'h0000_0001);
        check("ramClear", {31'h0, resetOut.ramClear}, 32'h0000_0001);
        waitc(15);
        apb(1'b0, A_RST, '0, 1'b0, 32'h0000_0000);
        check("modInReset", {31'h0, resetOut.modulesInReset}, 32'h0000_0000);
        check("ramClear", {31'h0, resetOut.ramClear}, 32'h0000_0000);
        $display("test module_reset done");
        apb(1'b1, A_PWR, 32'h0000_0091, 1'b0, 32'h0000_0000);
        waitc(3);
        check("pumpOff", {31'h0, powerOut.chargePumpOff}, 32'h0000_0001);
        check("standby", {31'h0, powerOut.standbyPower}, 32'h0000_0001);
        apb(1'b1, A_PWR, 32'h0000_00ff, 1'b0, 32'h0000_0000);
        apb(1'b0, A_PWR, '0, 1'b0, 32'h0000_0091);
        apb(1'b0, A_STAT, '0, 1'b0, 32'h0000_0006);
        apb(1'b1, A_PWR, 32'h0000_0081, 1'b0, 32'h0000_0000);
        waitc(3);
        check("pumpOff", {31'h0, powerOut.chargePumpOff}, 32'h0000_0001);
        $display("test powerdown done");
        apb(1'b1, A_PWR, 32'h0000_0080, 1'b0, 32'h0000_0000);
        waitc(3);
        check("standby", {31'h0, powerOut.standbyPower}, 32'h0000_0000);
        clockError <= 1'b1;
        waitc(6);
        check("standby", {31'h0, powerOut.standbyPower}, 32'h0000_0001);
        check("pumpOff", {31'h0, powerOut.chargePumpOff}, 32'h0000_0000);
        apb(1'b0, A_STAT, '0, 1'b0, 32'h0000_000d);
        clockError <= 1'b0;
        waitc(6);
        check("standby", {31'h0, powerOut.standbyPower}, 32'h0000_0000);
        $display("test clock_error done");
        // clocks are steady in this bench, so releasing is allowed
        apb(1'b1, A_PWR, 32'h0000_0000, 1'b0, 32'h0000_0000);
        waitc(3);
        check("procInReset", {31'h0, resetOut.processorInReset}, 32'h0000_0000);
        check("execRom", {31'h0, resetOut.executeFromRom}, 32'h0000_0000);
        $display("test processor_release done");
        for (int i = 0; i < 6; i++)
        begin
            rnd = $urandom();
            apb(1'b1, A_MUTE, rnd, 1'b0, 32'h0000_0000);
            apb(1'b0, A_MUTE, '0, 1'b0, rnd & 32'h0000_001f);
            waitc(2);
            check("leftMute", {31'h0, powerOut.leftMute}, {31'h0, rnd[4]});
            check("rightMute", {31'h0, powerOut.rightMute}, {31'h0, rnd[0]});
        end
        $display("test mute done");
        // register reset only issued from standby
        apb(1'b1, A_PWR, 32'h0000_0010, 1'b0, 32'h0000_0000);
        apb(1'b1, A_MUTE, 32'h0000_0011, 1'b0, 32'h0000_0000);
        apb(1'b1, A_RST, 32'h0000_0001, 1'b0, 32'h0000_0000);
        waitc(6);
        apb(1'b0, A_RST, '0, 1'b0, 32'h0000_0000);
        apb(1'b0, A_PWR, '0, 1'b0, 32'h0000_0080);
        apb(1'b0, A_MUTE, '0, 1'b0, 32'h0000_0000);
        check("execRom", {31'h0, resetOut.executeFromRom}, 32'h0000_0001);
        check("ramClear", {31'h0, resetOut.ramClear}, 32'h0000_0000);
        $display("test register_reset done");
        waitc(4);
        check("queue empty", expQ.size(), 32'h0000_0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
